/* File: bench/pclc_host.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Host model driving the single control wire
// ----------------------------------------------------------------
module pclc_host #(
	parameter int unsigned LATCH_CYCLES = 40
) (
	input wire logic clk_i,
	output logic pin_o
);
	// Shortest legal pulses, so bursts stay as quick as the wire allows
	localparam int unsigned LOW_CYC = 30;
	localparam int unsigned HIGH_CYC = 5;

	initial begin
		pin_o = 1'b0;
	end

	// Caller stands just after a rising edge; so does the return
	task automatic hold(input logic lvl, input int unsigned n);
		pin_o = lvl;
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic send(input int unsigned n);
		for (int unsigned i = 0; i < n; i++) begin
			hold(1'b0, LOW_CYC);
			hold(1'b1, HIGH_CYC);
		end
		// Margin past the latch so levels have settled on return
		hold(1'b1, LATCH_CYCLES + 5);
	endtask

	task automatic write(input int unsigned addr, input int unsigned data);
		send(16 + addr);
		send(data);
	endtask
endmodule

`default_nettype wire

/* File: bench/pulse_count_led_current_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none

module pulse_count_led_current_ctrl_test;
	localparam int unsigned LAT = 40;
	localparam int unsigned OFF = 60;
	// Roughly twice the cycles the scenarios need
	localparam int unsigned CEILING = 20000;

	logic clk_i;
	logic resetn_i;
	logic ctrl_pin;
	logic [3:0] near_dropout;
	logic active;
	logic [2:0] sel_addr;
	pclc_pkg::pclc_regs_s regs;
	pclc_pkg::pclc_conv_e conv;
	pclc_pkg::pclc_levels_t levels;
	int fails = 0;
	int checks_done = 0;
	int unsigned cycles = 0;

	pclc_ctrl #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) uut (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.ctrl_pin_i(ctrl_pin),
		.near_dropout_i(near_dropout),
		.active_o(active),
		.selected_addr_o(sel_addr),
		.regs_o(regs),
		.conv_mode_o(conv),
		.sink_level_o(levels)
	);

	pclc_host #(.LATCH_CYCLES(LAT)) host (
		.clk_i(clk_i),
		.pin_o(ctrl_pin)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == CEILING) begin
			fails = fails + 1;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Shared checks
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Register fields hold the written code minus one
	task automatic chk_regs(input logic [3:0] m, input logic [3:0] s, input logic [3:0] f, input logic [3:0] l);
		check({32'h0, regs}, {32'h0, m, s, f, l});
	endtask

	task automatic chk_lvl(input logic [11:0] m, input logic [11:0] s);
		check(levels, {s, m, m, m});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check({47'h0, active}, 48'h0);
		check({45'h0, sel_addr}, 48'h1);
		chk_regs(4'h0, 4'h0, 4'h0, 4'h0);
		check({46'h0, conv}, {46'h0, pclc_pkg::PCLC_CONV_1X});
		chk_lvl(12'h000, 12'h000);
	endtask

	task automatic t_both();
		host.write(1, 2);
		check({47'h0, active}, 48'h1);
		check({45'h0, sel_addr}, 48'h1);
		chk_regs(4'h1, 4'h1, 4'h0, 4'h0);
		chk_lvl(12'h6f4, 12'h6f4);
	endtask

	task automatic t_single();
		host.write(2, 16);
		check({45'h0, sel_addr}, 48'h2);
		chk_regs(4'hf, 4'h1, 4'h0, 4'h0);
		chk_lvl(12'h000, 12'h6f4);
		host.send(1);
		chk_regs(4'h0, 4'h1, 4'h0, 4'h0);
		chk_lvl(12'h7d0, 12'h6f4);
		host.write(3, 3);
		check({45'h0, sel_addr}, 48'h3);
		chk_regs(4'h0, 4'h2, 4'h0, 4'h0);
		chk_lvl(12'h7d0, 12'h636);
	endtask

	task automatic t_scale();
		host.write(4, 2);
		chk_regs(4'h0, 4'h2, 4'h1, 4'h0);
		chk_lvl(12'hbb8, 12'h94c);
		host.send(3);
		chk_lvl(12'h5dc, 12'h4a6);
		host.send(1);
		chk_lvl(12'h7d0, 12'h636);
	endtask

	task automatic t_low();
		logic [4:0] codes [5];
		logic [11:0] em [5];
		logic [11:0] es [5];
		codes = '{5'd6, 5'd10, 5'd16, 5'd13, 5'd8};
		em = '{12'h000, 12'h032, 12'h0c8, 12'h005, 12'h000};
		es = '{12'h032, 12'h000, 12'h0c8, 12'h005, 12'h0c8};
		host.write(4, 4);
		chk_lvl(12'h000, 12'h000);
		host.write(5, 1);
		check({45'h0, sel_addr}, 48'h5);
		for (int i = 0; i < 5; i++) begin
			host.send(codes[i]);
			check({44'h0, regs.low_power_level}, {43'h0, codes[i] - 5'd1});
			chk_lvl(em[i], es[i]);
		end
		chk_regs(4'h0, 4'h2, 4'h3, 4'h7);
	endtask

	task automatic t_drop();
		host.send(22);
		check({45'h0, sel_addr}, 48'h5);
		chk_regs(4'h0, 4'h2, 4'h3, 4'h7);
	endtask

	task automatic t_dropout();
		near_dropout = 4'h8;
		repeat (3) @(posedge clk_i);
		#1;
		check({46'h0, conv}, {46'h0, pclc_pkg::PCLC_CONV_1P5X});
		near_dropout = 4'h0;
		repeat (3) @(posedge clk_i);
		#1;
		near_dropout = 4'h1;
		repeat (3) @(posedge clk_i);
		#1;
		check({46'h0, conv}, {46'h0, pclc_pkg::PCLC_CONV_2X});
		near_dropout = 4'h0;
	endtask

	task automatic t_off();
		// Just short of the off timeout: a one-edge data write follows
		host.hold(1'b0, OFF - 2);
		host.hold(1'b1, LAT + 5);
		check({47'h0, active}, 48'h1);
		chk_regs(4'h0, 4'h2, 4'h3, 4'h0);
		host.hold(1'b0, OFF + 4);
		check({47'h0, active}, 48'h0);
		chk_regs(4'h0, 4'h0, 4'h0, 4'h0);
		check({46'h0, conv}, {46'h0, pclc_pkg::PCLC_CONV_1X});
		chk_lvl(12'h000, 12'h000);
		host.send(5);
		check({45'h0, sel_addr}, 48'h1);
		chk_regs(4'h4, 4'h4, 4'h0, 4'h0);
		chk_lvl(12'h4f6, 12'h4f6);
	endtask

	initial begin
		resetn_i = 1'b0;
		near_dropout = 4'h0;
		repeat (8) @(posedge clk_i);
		#1;
		resetn_i = 1'b1;
		t_reset();
		t_both();
		t_single();
		t_scale();
		t_low();
		t_drop();
		t_dropout();
		t_off();
		results();
	end
endmodule

`default_nettype wire

/* File: rtl/pclc_ctrl.sv */
// Functional notes
// R1: Commands come only from counting rising edges; count latches after high for latch_timeout.
// R2: Latched counts above 16 are addresses, 16 or fewer are data.
// R3: 17 to 21 edges select addresses 1 to 5.
// R4: Data counts 1 to 16 write the currently selected register.
// R5: Host sends address burst, waits latch_timeout, sends data burst, waits again.
// R6: Selected address stays, so repeated data bursts hit the same register.
// R7: Pin low longer than off_timeout shuts down sinks and converter.
// R8: Shutdown resets all registers to 1; first edge afterwards selects address 1.
// R9: Address 1 data loads both main and sub current registers.
// R10: Address 2 writes only main current, address 3 only sub current.
// R11: Address 4 writes full-scale select, address 5 writes low-current level.
// R12: Scale select 1 to 3 drives sinks from the level table column.
// R13: Scale select 4 is low-current mode, driven from low-current register only.
// R14: Writing 2 to scale select moves to 30 mA, keeping stored level codes.
// R15: The 20 mA scale is used until scale select is written.
// R16: Sixteen codes about 1 dB apart; code 1 full scale, code 16 zero.
// R17: Codes map to the tabulated levels, falling monotonically to code 15.
// R18: Near dropout the converter leaves 1X for 1.5X, then steps to 2X.
// R19: Host high pulses at least 50 ns; low pulses 0.3 to 75 us.
// R20: Scale select 1, 2, 3, 4 mean 20 mA, 30 mA, 15 mA, low-current.
// R21: Low codes 1-4 off; 5-8 sub, 9-12 main, 13-16 both at four levels.
// R22: Latched counts above 21 are dropped without any change.
`timescale 1ns/1ns
`default_nettype none

module pclc_ctrl #(
	parameter int unsigned LATCH_CYCLES = pclc_pkg::PCLC_LATCH_CYCLES,
	parameter int unsigned OFF_CYCLES = pclc_pkg::PCLC_OFF_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ctrl_pin_i,
	input wire logic [3:0] near_dropout_i,
	output logic active_o,
	output logic [2:0] selected_addr_o,
	output pclc_pkg::pclc_regs_s regs_o,
	output pclc_pkg::pclc_conv_e conv_mode_o,
	output pclc_pkg::pclc_levels_t sink_level_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enabled;
		logic pin_prev;
		logic drop_prev;
		logic [4:0] edge_cnt;
		logic [pclc_pkg::PCLC_TMR_W-1:0] hi_tmr;
		logic [pclc_pkg::PCLC_TMR_W-1:0] lo_tmr;
		logic [2:0] addr;
		pclc_pkg::pclc_regs_s regs;
		pclc_pkg::pclc_conv_e conv;
		pclc_pkg::pclc_levels_t levels;
	} pclc_state_s;

	localparam logic [pclc_pkg::PCLC_TMR_W-1:0] TMR_ZERO = '0;
	localparam logic [pclc_pkg::PCLC_TMR_W-1:0] TMR_ONE = {{(pclc_pkg::PCLC_TMR_W-1){1'b0}}, 1'b1};
	localparam logic [pclc_pkg::PCLC_TMR_W-1:0] LATCH_LAST = pclc_pkg::PCLC_TMR_W'(LATCH_CYCLES - 1);
	localparam logic [pclc_pkg::PCLC_TMR_W-1:0] OFF_LAST = pclc_pkg::PCLC_TMR_W'(OFF_CYCLES - 1);

	localparam pclc_state_s STATE_RST = '{
		enabled: 1'b0,
		pin_prev: 1'b0,
		drop_prev: 1'b0,
		edge_cnt: pclc_pkg::PCLC_CNT_ZERO,
		hi_tmr: TMR_ZERO,
		lo_tmr: TMR_ZERO,
		addr: pclc_pkg::PCLC_ADDR_BOTH,
		regs: pclc_pkg::PCLC_REGS_RST,
		conv: pclc_pkg::PCLC_CONV_1X,
		levels: '0
	};

	pclc_state_s st_reg;
	pclc_state_s st_next;
	// A net, since each sink lookup drives its own slice
	wire pclc_pkg::pclc_levels_t lut_level;
	logic rise;
	logic latch_fire;
	logic shut_fire;
	logic drop_rise;

	// ----------------------------------------------------------------
	// Level lookup, one per sink
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < pclc_pkg::PCLC_NUM_SINKS; gi++) begin : g_sink
			pclc_sink_level #(
				.IS_MAIN(gi < pclc_pkg::PCLC_NUM_MAIN)
			) u_level (
				.level_code_i((gi < pclc_pkg::PCLC_NUM_MAIN) ? st_reg.regs.main_channel_level
					: st_reg.regs.sub_channel_level),
				.full_scale_select_i(st_reg.regs.full_scale_select),
				.low_power_level_i(st_reg.regs.low_power_level),
				.level_o(lut_level[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register write by selected address
	// ----------------------------------------------------------------
	function automatic pclc_pkg::pclc_regs_s write_reg(input pclc_pkg::pclc_regs_s r, input logic [2:0] a,
		input logic [3:0] d);
		pclc_pkg::pclc_regs_s w;
		w = r;
		case (a)
			pclc_pkg::PCLC_ADDR_BOTH: begin
				w.main_channel_level = d; // [R9]
				w.sub_channel_level = d; // [R9]
			end
			pclc_pkg::PCLC_ADDR_MAIN: w.main_channel_level = d; // [R10]
			pclc_pkg::PCLC_ADDR_SUB: w.sub_channel_level = d; // [R10]
			// Only the select changes; stored level codes stay in place
			pclc_pkg::PCLC_ADDR_SCALE: w.full_scale_select = d; // [R11] [R14]
			pclc_pkg::PCLC_ADDR_LOW: w.low_power_level = d; // [R11]
			default: w = r;
		endcase
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.pin_prev = ctrl_pin_i;
		rise = ctrl_pin_i & ~st_reg.pin_prev;
		latch_fire = 1'b0;
		shut_fire = 1'b0;
		drop_rise = st_reg.enabled & (|near_dropout_i) & ~st_reg.drop_prev;
		st_next.drop_prev = st_reg.enabled & (|near_dropout_i);

		if (rise) begin
			st_next.hi_tmr = TMR_ZERO;
			st_next.lo_tmr = TMR_ZERO;
			if (!st_reg.enabled) begin
				// First edge out of shutdown wakes the part and counts itself
				st_next.enabled = 1'b1;
				st_next.addr = pclc_pkg::PCLC_ADDR_BOTH; // [R8]
				st_next.edge_cnt = pclc_pkg::PCLC_CNT_ONE; // [R1]
			end else if (st_reg.edge_cnt != pclc_pkg::PCLC_CNT_SAT) begin
				// Saturates so a runaway burst still reads as out of range
				st_next.edge_cnt = st_reg.edge_cnt + pclc_pkg::PCLC_CNT_ONE; // [R1]
			end
		end else if (ctrl_pin_i) begin
			st_next.lo_tmr = TMR_ZERO;
			if (st_reg.edge_cnt != pclc_pkg::PCLC_CNT_ZERO) begin
				if (st_reg.hi_tmr == LATCH_LAST) begin
					latch_fire = 1'b1; // [R1]
					st_next.hi_tmr = TMR_ZERO;
					st_next.edge_cnt = pclc_pkg::PCLC_CNT_ZERO;
				end else begin
					st_next.hi_tmr = st_reg.hi_tmr + TMR_ONE;
				end
			end
		end else begin
			// Low time inside a burst is far shorter than the off timeout
			st_next.hi_tmr = TMR_ZERO;
			if (st_reg.enabled) begin
				if (st_reg.lo_tmr == OFF_LAST) begin
					shut_fire = 1'b1; // [R7]
				end else begin
					st_next.lo_tmr = st_reg.lo_tmr + TMR_ONE;
				end
			end
		end

		if (latch_fire) begin
			if (st_reg.edge_cnt > pclc_pkg::PCLC_DATA_MAX_EDGES) begin // [R2]
				if (st_reg.edge_cnt <= pclc_pkg::PCLC_ADDR_MAX_EDGES) begin // [R22]
					st_next.addr = 3'(st_reg.edge_cnt - pclc_pkg::PCLC_DATA_MAX_EDGES); // [R3]
				end
			end else begin
				// Address is left alone so further data bursts reuse it
				st_next.regs = write_reg(st_reg.regs, st_reg.addr,
					4'(st_reg.edge_cnt - pclc_pkg::PCLC_CNT_ONE)); // [R4] [R6]
			end
		end

		// Converter starts in 1X and only climbs while on
		if (drop_rise) begin
			case (st_reg.conv)
				pclc_pkg::PCLC_CONV_1X: st_next.conv = pclc_pkg::PCLC_CONV_1P5X; // [R18]
				pclc_pkg::PCLC_CONV_1P5X: st_next.conv = pclc_pkg::PCLC_CONV_2X; // [R18]
				default: st_next.conv = pclc_pkg::PCLC_CONV_2X;
			endcase
		end

		if (shut_fire) begin
			st_next.enabled = 1'b0; // [R7]
			st_next.edge_cnt = pclc_pkg::PCLC_CNT_ZERO;
			st_next.lo_tmr = TMR_ZERO;
			st_next.regs = pclc_pkg::PCLC_REGS_RST; // [R8]
			st_next.conv = pclc_pkg::PCLC_CONV_1X; // [R7]
			st_next.drop_prev = 1'b0;
		end

		st_next.levels = st_reg.enabled ? lut_level : '0; // [R7]
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign active_o = st_reg.enabled;
	assign selected_addr_o = st_reg.addr;
	assign regs_o = st_reg.regs;
	assign conv_mode_o = st_reg.conv;
	assign sink_level_o = st_reg.levels;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_edge_count;
		rise && st_reg.enabled && st_reg.edge_cnt < pclc_pkg::PCLC_CNT_SAT
			|=> st_reg.edge_cnt == $past(st_reg.edge_cnt) + pclc_pkg::PCLC_CNT_ONE;
	endproperty
	a_edge_count: assert property (p_edge_count) else $error("edge not counted"); // [R1]

	property p_addr_sel;
		latch_fire && st_reg.edge_cnt > pclc_pkg::PCLC_DATA_MAX_EDGES && st_reg.edge_cnt <= pclc_pkg::PCLC_ADDR_MAX_EDGES
			|=> st_reg.addr == 3'($past(st_reg.edge_cnt) - pclc_pkg::PCLC_DATA_MAX_EDGES) && $stable(st_reg.regs);
	endproperty
	a_addr_sel: assert property (p_addr_sel) else $error("address burst decoded wrongly"); // [R3]

	property p_addr_discard;
		latch_fire && st_reg.edge_cnt > pclc_pkg::PCLC_ADDR_MAX_EDGES && !shut_fire
			|=> $stable(st_reg.addr) && $stable(st_reg.regs);
	endproperty
	a_addr_discard: assert property (p_addr_discard) else $error("overlong burst changed state"); // [R22]

	property p_data_keeps_addr;
		latch_fire && st_reg.edge_cnt <= pclc_pkg::PCLC_DATA_MAX_EDGES |=> $stable(st_reg.addr);
	endproperty
	a_data_keeps_addr: assert property (p_data_keeps_addr) else $error("data burst moved the address"); // [R6]

	property p_both_write;
		latch_fire && st_reg.edge_cnt <= pclc_pkg::PCLC_DATA_MAX_EDGES && st_reg.addr == pclc_pkg::PCLC_ADDR_BOTH
			|=> st_reg.regs.main_channel_level == 4'($past(st_reg.edge_cnt) - pclc_pkg::PCLC_CNT_ONE)
			&& st_reg.regs.sub_channel_level == st_reg.regs.main_channel_level;
	endproperty
	a_both_write: assert property (p_both_write) else $error("joint write did not load both levels"); // [R9]

	property p_main_only;
		latch_fire && st_reg.edge_cnt <= pclc_pkg::PCLC_DATA_MAX_EDGES && st_reg.addr == pclc_pkg::PCLC_ADDR_MAIN
			|=> $stable(st_reg.regs.sub_channel_level) && $stable(st_reg.regs.full_scale_select);
	endproperty
	a_main_only: assert property (p_main_only) else $error("main write touched other registers"); // [R10]

	property p_shutdown;
		st_reg.enabled && !ctrl_pin_i && st_reg.lo_tmr == OFF_LAST
			|=> !st_reg.enabled && st_reg.regs == pclc_pkg::PCLC_REGS_RST ##1 st_reg.levels == '0;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("off timeout did not reset"); // [R8]

	property p_off_dark;
		!st_reg.enabled ##1 !st_reg.enabled |-> st_reg.levels == '0 && st_reg.conv == pclc_pkg::PCLC_CONV_1X;
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("sinks lit while shut down"); // [R7]

	property p_wake_addr;
		rise && !st_reg.enabled |=> st_reg.enabled && st_reg.addr == pclc_pkg::PCLC_ADDR_BOTH;
	endproperty
	a_wake_addr: assert property (p_wake_addr) else $error("wake did not select address 1"); // [R8]

	property p_low_off;
		st_reg.enabled && st_reg.regs.full_scale_select == pclc_pkg::PCLC_FS_LOW
			&& st_reg.regs.low_power_level < pclc_pkg::PCLC_LOW_FIRST_ON |=> st_reg.levels == '0;
	endproperty
	a_low_off: assert property (p_low_off) else $error("low mode off code drove current"); // [R21]

	property p_conv_step;
		drop_rise && !shut_fire && st_reg.conv == pclc_pkg::PCLC_CONV_1X |=> st_reg.conv == pclc_pkg::PCLC_CONV_1P5X;
	endproperty
	a_conv_step: assert property (p_conv_step) else $error("converter did not start at 1.5X"); // [R18]

	c_addr_latch: cover property (latch_fire && st_reg.edge_cnt == pclc_pkg::PCLC_ADDR_MAX_EDGES);
	c_data_write: cover property (latch_fire && st_reg.addr == pclc_pkg::PCLC_ADDR_SCALE);
	c_shutdown: cover property (shut_fire);
	c_conv_2x: cover property (st_reg.conv == pclc_pkg::PCLC_CONV_2X);

endmodule

`default_nettype wire

/* File: rtl/pclc_pkg.sv */
package pclc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PCLC_CLK_PERIOD_NS = 10;
	localparam int unsigned PCLC_LATCH_TIMEOUT_NS = 500000;
	localparam int unsigned PCLC_OFF_TIMEOUT_NS = 500000;
	// Longest times, so the division rounds down
	localparam int unsigned PCLC_LATCH_CYCLES = PCLC_LATCH_TIMEOUT_NS / PCLC_CLK_PERIOD_NS;
	localparam int unsigned PCLC_OFF_CYCLES = PCLC_OFF_TIMEOUT_NS / PCLC_CLK_PERIOD_NS;
	localparam int unsigned PCLC_TMR_W = 17;

	// ----------------------------------------------------------------
	// Edge counts and addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] PCLC_CNT_ZERO = 5'h00;
	localparam logic [4:0] PCLC_CNT_ONE = 5'h01;
	localparam logic [4:0] PCLC_DATA_MAX_EDGES = 5'h10;
	localparam logic [4:0] PCLC_ADDR_MAX_EDGES = 5'h15;
	localparam logic [4:0] PCLC_CNT_SAT = 5'h1f;
	localparam logic [2:0] PCLC_ADDR_BOTH = 3'h1;
	localparam logic [2:0] PCLC_ADDR_MAIN = 3'h2;
	localparam logic [2:0] PCLC_ADDR_SUB = 3'h3;
	localparam logic [2:0] PCLC_ADDR_SCALE = 3'h4;
	localparam logic [2:0] PCLC_ADDR_LOW = 3'h5;

	// ----------------------------------------------------------------
	// Registers: each field stores the written code minus one
	// ----------------------------------------------------------------
	localparam logic [3:0] PCLC_REG_RST = 4'h0;
	localparam logic [3:0] PCLC_FS_20MA = 4'h0;
	localparam logic [3:0] PCLC_FS_30MA = 4'h1;
	localparam logic [3:0] PCLC_FS_15MA = 4'h2;
	localparam logic [3:0] PCLC_FS_LOW = 4'h3;
	localparam logic [3:0] PCLC_LOW_FIRST_ON = 4'h4;

	typedef struct packed {
		logic [3:0] main_channel_level;
		logic [3:0] sub_channel_level;
		logic [3:0] full_scale_select;
		logic [3:0] low_power_level;
	} pclc_regs_s;

	localparam pclc_regs_s PCLC_REGS_RST = '{PCLC_REG_RST, PCLC_REG_RST, PCLC_REG_RST, PCLC_REG_RST};

	typedef enum logic [1:0] {PCLC_CONV_1X, PCLC_CONV_1P5X, PCLC_CONV_2X} pclc_conv_e;

	// ----------------------------------------------------------------
	// Sink levels in units of 10 uA
	// ----------------------------------------------------------------
	typedef logic [11:0] pclc_lvl_t;
	typedef pclc_lvl_t [3:0] pclc_levels_t;
	localparam int unsigned PCLC_NUM_SINKS = 4;
	localparam int unsigned PCLC_NUM_MAIN = 3;
	localparam pclc_lvl_t PCLC_LVL_OFF = 12'h000;

	// Columns: 20 mA, 30 mA, 15 mA scale
	localparam pclc_lvl_t PCLC_SCALE_TBL [0:2][0:15] = '{
		'{12'h7d0, 12'h6f4, 12'h636, 12'h596, 12'h4f6, 12'h456, 12'h3fc, 12'h37a,
		  12'h316, 12'h2bc, 12'h276, 12'h23a, 12'h1fe, 12'h1b8, 12'h19a, 12'h000},
		'{12'hbb8, 12'ha6e, 12'h94c, 12'h85c, 12'h76c, 12'h686, 12'h5f0, 12'h532,
		  12'h4a6, 12'h41a, 12'h3b6, 12'h35c, 12'h2f8, 12'h29e, 12'h26c, 12'h000},
		'{12'h5dc, 12'h532, 12'h4a6, 12'h42e, 12'h3b6, 12'h33e, 12'h2f8, 12'h29e,
		  12'h258, 12'h208, 12'h1e0, 12'h1ae, 12'h17c, 12'h14a, 12'h136, 12'h000}
	};
	// 0.05, 0.5, 1 and 2 mA
	localparam pclc_lvl_t PCLC_LOW_TBL [0:3] = '{12'h005, 12'h032, 12'h064, 12'h0c8};

endpackage

/* File: rtl/pclc_sink_level.sv */
`timescale 1ns/1ns
`default_nettype none

module pclc_sink_level #(
	parameter bit IS_MAIN = 1'b1
) (
	input wire logic [3:0] level_code_i,
	input wire logic [3:0] full_scale_select_i,
	input wire logic [3:0] low_power_level_i,
	output logic [11:0] level_o
);

	// ----------------------------------------------------------------
	// Scale decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] scale_column(input logic [3:0] fs);
		case (fs)
			pclc_pkg::PCLC_FS_30MA: scale_column = 2'h1; // [R20]
			pclc_pkg::PCLC_FS_15MA: scale_column = 2'h2; // [R20]
			// Unlisted codes fall back to the default scale
			default: scale_column = 2'h0; // [R15]
		endcase
	endfunction

	logic low_group_on;

	always_comb begin
		// Codes 1-4 dark, 5-8 sub only, 9-12 main only, 13-16 both
		low_group_on = IS_MAIN ? low_power_level_i[3] : low_power_level_i[2]; // [R21]
		if (full_scale_select_i == pclc_pkg::PCLC_FS_LOW) begin
			// Current registers are ignored here
			level_o = low_group_on ? pclc_pkg::PCLC_LOW_TBL[low_power_level_i[1:0]] : pclc_pkg::PCLC_LVL_OFF; // [R13]
		end else begin
			level_o = pclc_pkg::PCLC_SCALE_TBL[scale_column(full_scale_select_i)][level_code_i]; // [R12] [R16] [R17]
		end
	end

endmodule

`default_nettype wire
